// *** design/erfp_pkg.sv ***
// package with constants and types of the emergency run fault policy block
package erfp_pkg;
	localparam int erfp_num_alarms = 25;
	localparam int erfp_alarm_w = 5;
	// alarm index encoding
	localparam logic [4:0] erfp_al_live_zero = 5'h00;
	localparam logic [4:0] erfp_al_mains_imb = 5'h01;
	localparam logic [4:0] erfp_al_overvolt = 5'h02;
	localparam logic [4:0] erfp_al_undervolt = 5'h03;
	localparam logic [4:0] erfp_al_inv_time = 5'h04;
	localparam logic [4:0] erfp_al_motor_time = 5'h05;
	localparam logic [4:0] erfp_al_thermistor = 5'h06;
	localparam logic [4:0] erfp_al_curr_limit = 5'h07;
	localparam logic [4:0] erfp_al_overcurr = 5'h08;
	localparam logic [4:0] erfp_al_earth = 5'h09;
	localparam logic [4:0] erfp_al_switch_mode = 5'h0a;
	localparam logic [4:0] erfp_al_short = 5'h0b;
	localparam logic [4:0] erfp_al_bus_tmo = 5'h0c;
	localparam logic [4:0] erfp_al_opt_tmo = 5'h0d;
	localparam logic [4:0] erfp_al_tune = 5'h0e;
	localparam logic [4:0] erfp_al_heatsink = 5'h0f;
	localparam logic [4:0] erfp_al_phase_u = 5'h10;
	localparam logic [4:0] erfp_al_phase_v = 5'h11;
	localparam logic [4:0] erfp_al_phase_w = 5'h12;
	localparam logic [4:0] erfp_al_opt_comm = 5'h13;
	localparam logic [4:0] erfp_al_gate = 5'h14;
	localparam logic [4:0] erfp_al_safe_stop = 5'h15;
	localparam logic [4:0] erfp_al_low_curr = 5'h16;
	localparam logic [4:0] erfp_al_was_active = 5'h17;
	localparam logic [4:0] erfp_al_unknown = 5'h18;
	// per-alarm policy masks
	localparam logic [24:0] erfp_lock_mask = 25'h1108f02;
	localparam logic [24:0] erfp_auto_mask = 25'h0100f00;
	localparam logic [24:0] erfp_bypass_mask = 25'h0108f02;
	// policy selections
	typedef enum logic [1:0] {
		erfp_pol_normal = 2'b00,
		erfp_pol_reset1 = 2'b01,
		erfp_pol_reset2 = 2'b10,
		erfp_pol_bypass = 2'b11
	} erfp_policy_t;
	// bypass output routing: four standard then four relay outputs
	localparam int erfp_num_outs = 8;
	localparam logic [2:0] erfp_first_relay = 3'h4;
	// apb register offsets
	localparam logic [7:0] erfp_reg_ctrl = 8'h00;
	localparam logic [7:0] erfp_reg_delay = 8'h04;
	localparam logic [7:0] erfp_reg_state = 8'h08;
	localparam logic [7:0] erfp_reg_irq_stat = 8'h0c;
	localparam logic [7:0] erfp_reg_irq_mask = 8'h10;
	localparam logic [7:0] erfp_reg_alarm = 8'h14;
	localparam logic [7:0] erfp_reg_cmd = 8'h18;
	// ctrl fields
	localparam int erfp_ctrl_pol_lsb = 0;
	localparam int erfp_ctrl_act_low = 2;
	localparam int erfp_ctrl_coast_dio = 3;
	localparam int erfp_ctrl_route_lsb = 4;
	localparam int erfp_ctrl_relay_fit = 7;
	localparam logic [31:0] erfp_ctrl_reset = 32'h00000008;
	// cmd fields
	localparam int erfp_cmd_reset = 0;
	localparam int erfp_cmd_clr_rec = 1;
	// interrupt status bits
	localparam int erfp_irq_trip = 0;
	localparam int erfp_irq_lock = 1;
	localparam int erfp_irq_bypass = 2;
	localparam int erfp_irq_warn = 3;
	localparam int erfp_irq_enter = 4;
	localparam int erfp_irq_w = 5;
	// bypass delay unit: 1 ms, tick derived from the 20 MHz clock
	localparam int erfp_clk_hz = 20000000;
	localparam int erfp_delay_unit_us = 1000;
	localparam int erfp_tick_cycles = erfp_clk_hz / 1000000 * erfp_delay_unit_us;
	localparam logic [15:0] erfp_delay_reset = 16'h000a;
	localparam int erfp_warn_half_ms = 250;
endpackage : erfp_pkg

// *** design/erfp_ctl_if.sv ***
// interface between the policy core and its tick divider
`timescale 1ns/1ps
interface erfp_ctl_if;
	logic tick;
	logic run;
	modport src (output tick, input run);
	modport dst (input tick, output run);
endinterface : erfp_ctl_if

// *** design/erfp_tick.sv ***
// millisecond tick divider for delays and warning flash
`timescale 1ns/1ps
module erfp_tick #(
	parameter int cycles = erfp_pkg::erfp_tick_cycles
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// tick toward the core
	erfp_ctl_if.src ctl
);
	import erfp_pkg::*;
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} erfp_tick_st_t;
	erfp_tick_st_t st;
	erfp_tick_st_t next_st;
	if (cycles < 2 || cycles > 65535) begin : g_bad_cycles
		$error("erfp_tick: cycles out of range");
	end
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!ctl.run) begin
			next_st.cnt = 16'h0000;
		end else if (st.cnt == 16'(cycles - 1)) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ctl.tick = st.tick;
endmodule : erfp_tick

// *** design/erfp_top.sv ***
// emergency run fault policy: trip, lock, auto-reset and bypass decisions
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module erfp_top #(
	parameter int tick_cycles = erfp_pkg::erfp_tick_cycles
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external pins, asynchronous
	input wire logic emerg_in,
	input wire logic coast_en_in,
	// alarm sources from the power stage, one level per alarm index
	input wire logic [erfp_pkg::erfp_num_alarms-1:0] alarm_in,
	// fieldbus coast bit, same clock
	input wire logic bus_coast,
	// retained emergency record from non-volatile storage, same clock
	input wire logic rec_restore,
	// outputs
	output logic trip,
	output logic locked,
	output logic emerg_active,
	output logic warn_flash,
	output logic coast,
	output logic [erfp_pkg::erfp_num_outs-1:0] bypass_out,
	output logic rec_store,
	output logic irq
);
	import erfp_pkg::*;
	typedef struct packed {
		logic [1:0] emerg_s;
		logic [1:0] coast_s;
		logic [erfp_num_alarms-1:0] al_s1;
		logic [erfp_num_alarms-1:0] al_s2;
		logic [31:0] ctrl;
		logic [15:0] delay;
		logic [erfp_irq_w-1:0] irq_stat;
		logic [erfp_irq_w-1:0] irq_mask;
		logic [erfp_num_alarms-1:0] trip_al;
		logic trip;
		logic locked;
		logic bypass_pend;
		logic bypass_on;
		logic [15:0] bp_cnt;
		logic warn;
		logic [8:0] flash_cnt;
		logic flash;
		logic record;
		logic act_d;
		logic rd_wait;
		logic [31:0] prdata;
	} erfp_st_t;
	erfp_st_t st;
	erfp_st_t next_st;
	erfp_ctl_if ctl ();
	// the divider counts in 16 bits and needs two states per tick
	if (tick_cycles < 2 || tick_cycles > 65535) begin : g_bad_tick
		$error("erfp_top: tick_cycles out of range");
	end
	erfp_tick #(.cycles(tick_cycles)) u_tick (
		.clk(clk),
		.nrst(nrst),
		.ctl(ctl)
	);
	logic wr;
	logic rd;
	logic [1:0] pol;
	logic act_lvl;
	logic bus_coast_eff;
	logic coast_req;
	logic active;
	logic [erfp_num_alarms-1:0] new_al;
	logic [erfp_num_alarms-1:0] eff_al;
	logic [erfp_num_alarms-1:0] lock_al;
	logic [erfp_irq_w-1:0] ev;
	logic sw_reset;
	logic mapped;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pol = st.ctrl[erfp_ctrl_pol_lsb +: 2];
	assign act_lvl = st.emerg_s[1] ^ st.ctrl[erfp_ctrl_act_low];
	// bus coast and record restore share our clock, so no synchroniser
	// bus coast gating
	assign bus_coast_eff = bus_coast && !st.ctrl[erfp_ctrl_coast_dio];
	assign coast_req = !st.coast_s[1] || bus_coast_eff;
	assign active = act_lvl && (pol != erfp_pol_normal) && !coast_req;
	assign sw_reset = wr && (paddr == erfp_reg_cmd) && pwdata[erfp_cmd_reset];
	assign mapped = (paddr <= erfp_reg_cmd) && (paddr[1:0] == 2'b00);
	// was-active alarm raised after return to normal
	always_comb begin
		new_al = st.al_s2;
		new_al[erfp_al_was_active] = st.record && !active;
	end
	always_comb begin
		eff_al = new_al;
		lock_al = new_al & erfp_lock_mask;
		if (active) begin
			if (pol == erfp_pol_bypass) begin
				// bypass set acts on the hard faults plus imbalance and heatsink
				eff_al = new_al & erfp_bypass_mask;
			end else begin
				// hard faults only under auto reset
				eff_al = new_al & erfp_auto_mask;
			end
			lock_al = new_al & erfp_auto_mask;
		end
	end
	always_comb begin
		next_st = st;
		ev = '0;
		next_st.emerg_s = {st.emerg_s[0], emerg_in};
		next_st.coast_s = {st.coast_s[0], coast_en_in};
		next_st.al_s1 = alarm_in;
		next_st.al_s2 = st.al_s1;
		next_st.act_d = active;
		next_st.rd_wait = rd && !st.rd_wait;
		if (active || rec_restore) begin
			next_st.record = 1'b1;
		end else if (wr && (paddr == erfp_reg_cmd) && pwdata[erfp_cmd_clr_rec]) begin
			next_st.record = 1'b0;
		end
		if (active && !st.act_d) begin
			ev[erfp_irq_enter] = 1'b1;
		end
		if (|eff_al && !st.trip) begin
			next_st.trip = 1'b1;
			next_st.trip_al = eff_al;
			ev[erfp_irq_trip] = 1'b1;
			if (|lock_al) begin
				next_st.locked = 1'b1;
				ev[erfp_irq_lock] = 1'b1;
			end
			if (active && pol == erfp_pol_bypass) begin
				next_st.bypass_pend = 1'b1;
				next_st.bp_cnt = 16'h0000;
			end
		end else if (st.trip) begin
			// auto reset when the alarm clears
			if (active && (pol == erfp_pol_reset1 || pol == erfp_pol_reset2)) begin
				if (!(|(eff_al & st.trip_al & ~erfp_auto_mask)) && !(|eff_al)) begin
					next_st.trip = 1'b0;
					next_st.locked = 1'b0;
				end
			end
			// manual reset, locked or not, needs the alarm gone
			if (sw_reset && !(|eff_al)) begin
				next_st.trip = 1'b0;
				next_st.locked = 1'b0;
			end
		end
		// delay from trip to bypass output
		if (st.bypass_pend && ctl.tick) begin
			if (st.bp_cnt + 16'h0001 >= st.delay) begin
				next_st.bypass_pend = 1'b0;
				next_st.bypass_on = 1'b1;
				ev[erfp_irq_bypass] = 1'b1;
			end else begin
				next_st.bp_cnt = st.bp_cnt + 16'h0001;
			end
		end
		if (!active || pol != erfp_pol_bypass) begin
			next_st.bypass_pend = 1'b0;
			next_st.bypass_on = 1'b0;
		end
		if (active && |(new_al & ~eff_al)) begin
			if (!st.warn) begin
				ev[erfp_irq_warn] = 1'b1;
			end
			next_st.warn = 1'b1;
		end else if (!active) begin
			next_st.warn = 1'b0;
		end
		// each warning starts with a full dark phase, not a stale one
		if (!st.warn) begin
			next_st.flash_cnt = 9'h000;
			next_st.flash = 1'b0;
		end else if (ctl.tick) begin
			if (st.flash_cnt == 9'(erfp_warn_half_ms - 1)) begin
				next_st.flash_cnt = 9'h000;
				next_st.flash = !st.flash;
			end else begin
				next_st.flash_cnt = st.flash_cnt + 9'h001;
			end
		end
		// registers
		// writes to read-only or unmapped offsets are dropped
		if (wr) begin
			case (paddr)
				erfp_reg_ctrl: begin
					next_st.ctrl = {24'h000000, pwdata[7:0]};
				end
				erfp_reg_delay: begin
					next_st.delay = pwdata[15:0];
				end
				erfp_reg_irq_mask: begin
					next_st.irq_mask = pwdata[erfp_irq_w-1:0];
				end
				default: begin
				end
			endcase
		end
		// set wins over write-one-to-clear
		if (wr && paddr == erfp_reg_irq_stat) begin
			next_st.irq_stat = (st.irq_stat & ~pwdata[erfp_irq_w-1:0]) | ev;
		end else begin
			next_st.irq_stat = st.irq_stat | ev;
		end
		next_st.prdata = 32'h00000000;
		if (rd) begin
			case (paddr)
				erfp_reg_ctrl: begin
					next_st.prdata = st.ctrl;
				end
				erfp_reg_delay: begin
					next_st.prdata = {16'h0000, st.delay};
				end
				erfp_reg_state: begin
					next_st.prdata = {24'h000000, st.record, st.warn,
						st.bypass_on, st.bypass_pend, active, st.locked, st.trip, coast_req};
				end
				erfp_reg_irq_stat: begin
					next_st.prdata = {27'h0000000, st.irq_stat};
				end
				erfp_reg_irq_mask: begin
					next_st.prdata = {27'h0000000, st.irq_mask};
				end
				erfp_reg_alarm: begin
					next_st.prdata = {7'h00, st.trip_al};
				end
				default: begin
					next_st.prdata = 32'h00000000;
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.ctrl <= erfp_ctrl_reset;
			st.delay <= erfp_delay_reset;
		end else begin
			st <= next_st;
		end
	end
	// tick only when something times
	assign ctl.run = st.bypass_pend || st.warn;
	// registered read data is one cycle late, so pready waits one cycle
	assign pready = !(psel && penable && !pwrite) || st.rd_wait;
	assign pslverr = psel && penable && !mapped;
	assign prdata = st.prdata;
	assign trip = st.trip;
	assign locked = st.locked;
	assign emerg_active = active;
	assign warn_flash = st.warn && st.flash;
	assign coast = coast_req;
	assign rec_store = st.record;
	assign irq = |(st.irq_stat & st.irq_mask);
	genvar gi;
	generate
		for (gi = 0; gi < erfp_num_outs; gi++) begin : g_out
			assign bypass_out[gi] = st.bypass_on
				&& (st.ctrl[erfp_ctrl_route_lsb +: 3] == 3'(gi))
				&& (3'(gi) < erfp_first_relay || st.ctrl[erfp_ctrl_relay_fit]);
		end
	endgenerate
endmodule : erfp_top

// *** tb/erfp_partner.sv ***
// model of the power stage and the external emergency signals
`timescale 1ns/1ps
module erfp_partner (
	// clock
	input wire logic clk,
	// toward the block
	output logic emerg_in,
	output logic coast_en_in,
	output logic [erfp_pkg::erfp_num_alarms-1:0] alarm_in,
	output logic bus_coast,
	output logic rec_restore
);
	import erfp_pkg::*;
	initial begin
		emerg_in = 1'b0;
		coast_en_in = 1'b1;
		alarm_in = 25'h0000000;
		bus_coast = 1'b0;
		rec_restore = 1'b0;
	end
	// alarms are levels that stay until the fault clears
	task put(input logic e, input logic b, input logic r, input logic [24:0] a);
		@(posedge clk);
		emerg_in <= e;
		bus_coast <= b;
		rec_restore <= r;
		alarm_in <= a;
	endtask : put
	// coast pin dropped only to show that it stops emergency run
	task coast_pin(input logic v);
		@(posedge clk);
		coast_en_in <= v;
	endtask : coast_pin
endmodule : erfp_partner

// *** tb/erfp_monitor.sv ***
// checker of bus handshake, bypass routing and emergency record
`timescale 1ns/1ps
module erfp_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// pins and status
	input wire logic coast_en_in,
	input wire logic rec_restore,
	input wire logic locked,
	input wire logic emerg_active,
	input wire logic [erfp_pkg::erfp_num_outs-1:0] bypass_out,
	input wire logic rec_store
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	wr_ready_a: assert property (psel && penable && pwrite |-> pready)
		else $error("write stalled");
	rd_wait_a: assert property (psel && penable && !pwrite && !$past(penable) |-> !pready)
		else $error("read answered early");
	rd_done_a: assert property (psel && penable && !pready |=> pready)
		else $error("read answered late");
	bad_addr_a: assert property (psel && penable && (paddr > 8'h18 || paddr[1:0] != 2'h0)
		|-> pslverr) else $error("bad address accepted");
	good_addr_a: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("good address refused");
	bypass_onehot_a: assert property ($onehot0(bypass_out))
		else $error("bypass on several outputs");
	coast_stop_a: assert property (!coast_en_in [*4] |-> !emerg_active)
		else $error("emergency run while coasting");
	rec_set_a: assert property (emerg_active |-> ##[0:2] rec_store)
		else $error("record not set");
	rec_load_a: assert property (rec_restore |-> ##[1:3] rec_store)
		else $error("record not restored");
	cover property (bypass_out != 8'h00);
	cover property (locked);
	cover property (emerg_active && rec_store);
endmodule : erfp_monitor

// *** tb/erfp_top_tb_top.sv ***
// testbench for the emergency run fault policy block
`timescale 1ns/1ps
module erfp_top_tb_top;
	import erfp_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic trip, locked, emerg_active, warn_flash, coast, rec_store, irq;
	logic emerg_in, coast_en_in, bus_coast, rec_restore;
	logic [erfp_num_alarms-1:0] alarm_in;
	logic [erfp_num_outs-1:0] bypass_out;
	int n_fail = 0;
	int check_count = 0;
	erfp_partner pm (.clk(clk), .emerg_in(emerg_in), .coast_en_in(coast_en_in),
		.alarm_in(alarm_in), .bus_coast(bus_coast), .rec_restore(rec_restore));
	// a short tick keeps the millisecond timings within a short run
	erfp_top #(.tick_cycles(20)) dut (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.emerg_in(emerg_in), .coast_en_in(coast_en_in), .alarm_in(alarm_in),
		.bus_coast(bus_coast), .rec_restore(rec_restore), .trip(trip), .locked(locked),
		.emerg_active(emerg_active), .warn_flash(warn_flash), .coast(coast),
		.bypass_out(bypass_out), .rec_store(rec_store), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task conclude();
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// read data and error are taken at the edge where pready is high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task rst();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
	endtask : rst
	initial begin
		#(50 * 30000);
		n_fail++;
		conclude();
	end
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		rst();
		bus(1'b0, erfp_reg_ctrl, 32'h0);
		chk("ctrl", erfp_ctrl_reset, d);
		bus(1'b0, erfp_reg_delay, 32'h0);
		chk("delay", {16'h0000, erfp_delay_reset}, d);
		bus(1'b0, 8'h1c, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		pm.put(1'b0, 1'b1, 1'b0, 25'h0);
		wt(6);
		chk("coast", 32'h0, 32'(coast));
		bus(1'b1, erfp_reg_ctrl, 32'h0);
		wt(6);
		chk("coast", 32'h1, 32'(coast));
		pm.put(1'b1, 1'b0, 1'b0, 25'h1 << erfp_al_overvolt);
		wt(8);
		chk("active", 32'h0, 32'(emerg_active));
		chk("trip", 32'h1, 32'(trip));
		chk("lock", 32'h0, 32'(locked));
		pm.put(1'b1, 1'b0, 1'b0, 25'h0);
		wt(4);
		bus(1'b1, erfp_reg_cmd, 32'h1);
		wt(2);
		chk("trip", 32'h0, 32'(trip));
		pm.put(1'b1, 1'b0, 1'b0, 25'h1 << erfp_al_heatsink);
		wt(8);
		chk("trip", 32'h1, 32'(trip));
		chk("lock", 32'h1, 32'(locked));
		// auto-reset selections; hard faults still lock
		for (int p = 1; p < 3; p++) begin
			pm.put(1'b1, 1'b0, 1'b0, 25'h0);
			rst();
			bus(1'b1, erfp_reg_ctrl, 32'h8 | p);
			wt(6);
			chk("active", 32'h1, 32'(emerg_active));
			chk("rec", 32'h1, 32'(rec_store));
			pm.coast_pin(1'b0);
			wt(6);
			chk("active", 32'h0, 32'(emerg_active));
			chk("trip", 32'h1, 32'(trip));
			pm.coast_pin(1'b1);
			wt(6);
			chk("active", 32'h1, 32'(emerg_active));
			chk("trip", 32'h0, 32'(trip));
			pm.put(1'b1, 1'b0, 1'b0, 25'h1 << erfp_al_overvolt);
			wt(8);
			chk("trip", 32'h0, 32'(trip));
			bus(1'b0, erfp_reg_state, 32'h0);
			chk("warn", 32'h1, 32'(d[6]));
			wt(4900);
			chk("flash", 32'h0, 32'(warn_flash));
			wt(200);
			chk("flash", 32'h1, 32'(warn_flash));
			pm.put(1'b1, 1'b0, 1'b0, 25'h1 << erfp_al_overcurr);
			wt(8);
			chk("trip", 32'h1, 32'(trip));
			chk("lock", 32'h1, 32'(locked));
			pm.put(1'b1, 1'b0, 1'b0, 25'h0);
			wt(10);
			chk("trip", 32'h0, 32'(trip));
		end
		// bypass, active-low activation, relay output 5
		pm.put(1'b0, 1'b0, 1'b0, 25'h0);
		rst();
		bus(1'b1, erfp_reg_delay, 32'h2);
		bus(1'b1, erfp_reg_irq_mask, 32'h4);
		bus(1'b1, erfp_reg_ctrl, 32'hdf);
		wt(6);
		chk("active", 32'h1, 32'(emerg_active));
		pm.put(1'b0, 1'b0, 1'b0, 25'h1 << erfp_al_heatsink);
		wt(8);
		chk("trip", 32'h1, 32'(trip));
		chk("lock", 32'h0, 32'(locked));
		wt(28);
		chk("bypass", 32'h0, 32'(bypass_out));
		for (int i = 0; i < 200 && bypass_out === 8'h00; i++) @(negedge clk);
		chk("bypass", 32'h20, 32'(bypass_out));
		chk("trip", 32'h1, 32'(trip));
		chk("irq", 32'h1, 32'(irq));
		bus(1'b1, erfp_reg_irq_stat, 32'h4);
		bus(1'b0, erfp_reg_irq_stat, 32'h0);
		chk("stat", 32'h0, 32'(d[erfp_irq_bypass]));
		chk("irq", 32'h0, 32'(irq));
		// retained record back in normal handling
		pm.put(1'b0, 1'b0, 1'b0, 25'h0);
		rst();
		pm.put(1'b0, 1'b0, 1'b1, 25'h0);
		pm.put(1'b0, 1'b0, 1'b0, 25'h0);
		wt(8);
		chk("rec", 32'h1, 32'(rec_store));
		chk("trip", 32'h1, 32'(trip));
		bus(1'b0, erfp_reg_alarm, 32'h0);
		chk("alarm", 32'h1, 32'(d[erfp_al_was_active]));
		bus(1'b1, erfp_reg_cmd, 32'h2);
		wt(3);
		chk("rec", 32'h0, 32'(rec_store));
		conclude();
	end
endmodule : erfp_top_tb_top
bind erfp_top erfp_monitor mon (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.coast_en_in(coast_en_in), .rec_restore(rec_restore), .locked(locked),
	.emerg_active(emerg_active), .bypass_out(bypass_out), .rec_store(rec_store));
